// [rtl/rid_pkg.sv]
// package: constants and carriers for the instruction decoder core
package rid_pkg;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_CLKS = 2;
  localparam logic [2:0] STALL_3CYC = 3'((3 - 1) * CYC_CLKS);
  localparam logic [2:0] STALL_4CYC = 3'((4 - 1) * CYC_CLKS);
  // -------------------------------------------------------------
  // status, option, mode
  // -------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_NIB = 1;
  localparam int ST_Z = 2;
  localparam int ST_SLP = 3;
  localparam int ST_TO = 4;
  localparam int ST_PA = 5;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [3:0] MODE_RST = 4'hF;
  localparam int OPT_PSA = 3;
  localparam logic [3:0] MODE_COMPARE = 4'h8;
  localparam logic [3:0] MODE_WAKE_PEND = 4'h9;
  localparam logic [2:0] PORT_B = 3'h6;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CORE = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CARRY_FUSE = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_EXEC = 2'b01,
    ST_STALL = 2'b10,
    ST_SLEEP = 2'b11
  } rid_state_e;
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] ind_ptr;
    logic [11:0] pc;
  } rid_shadow_s;
  typedef struct packed {
    logic we;
    logic [2:0] port;
    logic [7:0] data;
  } rid_pctl_s;
endpackage

// [rtl/rid_core.sv]
// instruction decode and execute core with its control register slave
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - move accumulator into file register, no flags
// - load accumulator from file register, zero flag
// - file minus accumulator, carry fuse, three flags
// - immediate into accumulator, flags untouched
// - inverse, decrement, increment into accumulator, zero
// - rotate through carry into accumulator
// - nibble swap into accumulator, no flags
// - mode into accumulator, upper nibble zero
// - decrement/increment into accumulator, skip on zero
// - accumulator or immediate into mode register
// - port control write, exchange for port B only in MODE_COMPARE or MODE_WAKE_PEND
// - accumulator into option register
// - test file register, set zero flag
// - call pushes return, page and immediate
// - jump loads nine bits plus page
// - return pops; literal return loads accumulator
// - page return restores page bits too
// - interrupt return restores shadows, optional counter add
// - bank field into pointer bits 7:5
// - program memory read through mode:accumulator, 4 cycles
// - page field into status bits 7:5
// - sleep clears watchdog, sets timeout, stops
module rid_core #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [7:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [7:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic [11:0] PMEM_ADDR_O,
  input wire logic [11:0] PMEM_DATA_I,
  output logic [7:0] FILE_ADDR_O,
  input wire logic [7:0] FILE_RDATA_I,
  output logic FILE_WE_O,
  output logic [7:0] FILE_WDATA_O,
  output rid_pkg::rid_pctl_s PCTL_O,
  input wire logic [7:0] PCTL_RDATA_I,
  output logic [3:0] MODE_O,
  output logic [7:0] OPTION_O,
  input rid_pkg::rid_shadow_s SHADOW_I,
  output logic RTCNT_ADD_O,
  output logic [7:0] RTCNT_ADDEND_O,
  output logic WATCHDOG_CLR_O,
  output logic PRESC_CLR_O,
  output logic SLEEP_O,
  input wire logic WAKE_I
);
  import rid_pkg::*;
  localparam int SPW = $clog2(STACK_DEPTH);

  rid_state_e state;
  logic [11:0] ir;
  logic [11:0] pc;
  logic [7:0] w;
  logic [7:0] status;
  logic [7:0] ind_ptr;
  logic skip;
  logic pm_read;
  logic [2:0] stall_cnt;
  logic [SPW-1:0] sp;
  logic [11:0] stack [STACK_DEPTH];
  logic [1:0] ctrl;
  logic [7:0] f;
  logic bin;
  logic [8:0] sub_r;
  logic [4:0] sub_n;
  logic [7:0] f_dec;
  logic [7:0] f_inc;
  logic [SPW-1:0] sp_m1;
  logic [11:0] tos;
  logic ex;
  logic push;

  function automatic logic zf(input logic [7:0] v);
    zf = (v == 8'h00);
  endfunction

  function automatic logic [7:0] word_of(input logic [7:0] a);
    word_of = {a[7:2], 2'b00};
  endfunction

  // ---------------------------------------------------------------
  // operand arithmetic
  // ---------------------------------------------------------------
  always_comb begin
    f = FILE_RDATA_I;
    bin = !ctrl[CTRL_CARRY_FUSE] && !status[ST_C];
    sub_r = {1'b0, f} - {1'b0, w} - {8'h00, bin};
    sub_n = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, bin};
    f_dec = f - 8'h01;
    f_inc = f + 8'h01;
    sp_m1 = sp - SPW'(1);
    tos = stack[sp_m1];
    ex = CE_I && (state == ST_EXEC) && !skip;
    push = ex && (ir ==? 12'b1001_????_????);
  end

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (push) begin
      stack[sp] <= pc;
    end
  end

  // ---------------------------------------------------------------
  // fetch, execute, stall, sleep
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_FETCH;
      ir <= 12'h000;
      pc <= 12'h000;
      w <= 8'h00;
      status <= STATUS_RST;
      ind_ptr <= 8'h00;
      skip <= 1'b0;
      pm_read <= 1'b0;
      stall_cnt <= 3'h0;
      sp <= '0;
      PMEM_ADDR_O <= 12'h000;
      FILE_ADDR_O <= 8'h00;
      FILE_WE_O <= 1'b0;
      FILE_WDATA_O <= 8'h00;
      PCTL_O <= '0;
      MODE_O <= MODE_RST;
      OPTION_O <= OPTION_RST;
      RTCNT_ADD_O <= 1'b0;
      RTCNT_ADDEND_O <= 8'h00;
      WATCHDOG_CLR_O <= 1'b0;
      PRESC_CLR_O <= 1'b0;
      SLEEP_O <= 1'b0;
    end else if (CE_I) begin
      FILE_WE_O <= 1'b0;
      PCTL_O.we <= 1'b0;
      RTCNT_ADD_O <= 1'b0;
      WATCHDOG_CLR_O <= 1'b0;
      PRESC_CLR_O <= 1'b0;
      case (state)
        ST_FETCH: begin
          if (ctrl[CTRL_RUN]) begin
            ir <= PMEM_DATA_I;
            FILE_ADDR_O <= {ind_ptr[7:5], PMEM_DATA_I[4:0]};
            pc <= pc + 12'h001;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_FETCH;
          PMEM_ADDR_O <= pc;
          if (skip) begin
            skip <= 1'b0;
          end else begin
            casez (ir)
              12'b0000_001?_????: begin
                FILE_WE_O <= 1'b1;
                FILE_WDATA_O <= w;
              end
              12'b0010_000?_????: begin
                w <= f;
                status[ST_Z] <= zf(f);
              end
              12'b0000_100?_????: begin
                w <= sub_r[7:0];
                status[ST_C] <= !sub_r[8];
                status[ST_NIB] <= !sub_n[4];
                status[ST_Z] <= zf(sub_r[7:0]);
              end
              12'b1100_????_????: begin
                w <= ir[7:0];
              end
              12'b0010_010?_????: begin
                w <= ~f;
                status[ST_Z] <= zf(~f);
              end
              12'b0000_110?_????: begin
                w <= f_dec;
                status[ST_Z] <= zf(f_dec);
              end
              12'b0010_100?_????: begin
                w <= f_inc;
                status[ST_Z] <= zf(f_inc);
              end
              12'b0011_010?_????: begin
                w <= {f[6:0], status[ST_C]};
                status[ST_C] <= f[7];
              end
              12'b0011_000?_????: begin
                w <= {status[ST_C], f[7:1]};
                status[ST_C] <= f[0];
              end
              12'b0011_100?_????: begin
                w <= {f[3:0], f[7:4]};
              end
              12'b0000_0100_0010: begin
                w <= {4'h0, MODE_O};
              end
              12'b0010_110?_????: begin
                w <= f_dec;
                skip <= zf(f_dec);
              end
              12'b0011_110?_????: begin
                w <= f_inc;
                skip <= zf(f_inc);
              end
              12'b0000_0100_0011: begin
                MODE_O <= w[3:0];
              end
              12'b0000_0101_????: begin
                MODE_O <= ir[3:0];
              end
              12'b0000_0000_0101, 12'b0000_0000_011?: begin
                PCTL_O.we <= 1'b1;
                PCTL_O.port <= ir[2:0];
                PCTL_O.data <= w;
                if (ir[2:0] == PORT_B && (MODE_O == MODE_WAKE_PEND ||
                    MODE_O == MODE_COMPARE)) begin
                  w <= PCTL_RDATA_I;
                end
              end
              12'b0000_0000_0010: begin
                OPTION_O <= w;
              end
              12'b0010_001?_????: begin
                FILE_WE_O <= 1'b1;
                FILE_WDATA_O <= f;
                status[ST_Z] <= zf(f);
              end
              12'b1001_????_????: begin
                sp <= sp + SPW'(1);
                pc <= {status[7:5], 1'b0, ir[7:0]};
                PMEM_ADDR_O <= {status[7:5], 1'b0, ir[7:0]};
                stall_cnt <= STALL_3CYC;
                state <= ST_STALL;
              end
              12'b101?_????_????: begin
                pc <= {status[7:5], ir[8:0]};
                PMEM_ADDR_O <= {status[7:5], ir[8:0]};
                stall_cnt <= STALL_3CYC;
                state <= ST_STALL;
              end
              12'b0000_0000_110?, 12'b1000_????_????: begin
                sp <= sp_m1;
                pc <= tos;
                PMEM_ADDR_O <= tos;
                stall_cnt <= STALL_3CYC;
                state <= ST_STALL;
                if (ir[11]) begin
                  w <= ir[7:0];
                end
                if (ir[0] && !ir[11]) begin
                  status[7:5] <= tos[11:9];
                end
              end
              12'b0000_0000_111?: begin
                w <= SHADOW_I.w;
                status <= {SHADOW_I.status[7:5], status[ST_TO],
                           status[ST_SLP], SHADOW_I.status[2:0]};
                ind_ptr <= SHADOW_I.ind_ptr;
                pc <= SHADOW_I.pc;
                PMEM_ADDR_O <= SHADOW_I.pc;
                RTCNT_ADD_O <= ir[0];
                RTCNT_ADDEND_O <= w;
                stall_cnt <= STALL_3CYC;
                state <= ST_STALL;
              end
              12'b0000_0001_1???: begin
                ind_ptr[7:5] <= ir[2:0];
              end
              12'b0000_0100_0001: begin
                PMEM_ADDR_O <= {MODE_O, w};
                pm_read <= 1'b1;
                stall_cnt <= STALL_4CYC;
                state <= ST_STALL;
              end
              12'b0000_0001_0???: begin
                status[7:5] <= ir[2:0];
              end
              12'b0000_0000_0011: begin
                WATCHDOG_CLR_O <= 1'b1;
                PRESC_CLR_O <= OPTION_O[OPT_PSA];
                status[ST_TO] <= 1'b1;
                status[ST_SLP] <= 1'b0;
                SLEEP_O <= 1'b1;
                state <= ST_SLEEP;
              end
              default: begin
              end
            endcase
          end
        end
        ST_STALL: begin
          stall_cnt <= stall_cnt - 3'h1;
          if (stall_cnt == 3'h1) begin
            state <= ST_FETCH;
            if (pm_read) begin
              {MODE_O, w} <= PMEM_DATA_I;
              PMEM_ADDR_O <= pc;
              pm_read <= 1'b0;
            end
          end
        end
        ST_SLEEP: begin
          if (WAKE_I) begin
            SLEEP_O <= 1'b0;
            state <= ST_FETCH;
          end
        end
        default: begin
          state <= ST_FETCH;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register bus: write path
  // ---------------------------------------------------------------
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AXI_AWREADY_O <= 1'b1;
      AXI_WREADY_O <= 1'b1;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl <= CTRL_RST;
    end else if (CE_I) begin
      if (AXI_AWVALID_I && AXI_AWREADY_O) begin
        awaddr_q <= AXI_AWADDR_I;
        AXI_AWREADY_O <= 1'b0;
      end
      if (AXI_WVALID_I && AXI_WREADY_O) begin
        wdata_q <= AXI_WDATA_I;
        wstrb_q <= AXI_WSTRB_I;
        AXI_WREADY_O <= 1'b0;
      end
      if (!AXI_AWREADY_O && !AXI_WREADY_O && !AXI_BVALID_O) begin
        AXI_BVALID_O <= 1'b1;
        if (word_of(awaddr_q) == REG_CTRL) begin
          AXI_BRESP_O <= RESP_OKAY;
          if (wstrb_q[0]) begin
            ctrl <= wdata_q[1:0];
          end
        end else begin
          AXI_BRESP_O <= RESP_SLVERR;
        end
      end
      if (AXI_BVALID_O && AXI_BREADY_I) begin
        AXI_BVALID_O <= 1'b0;
        AXI_AWREADY_O <= 1'b1;
        AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register bus: read path
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AXI_ARREADY_O <= 1'b1;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= 32'h0000_0000;
      AXI_RRESP_O <= RESP_OKAY;
    end else if (CE_I) begin
      if (AXI_ARVALID_I && AXI_ARREADY_O) begin
        AXI_ARREADY_O <= 1'b0;
        AXI_RVALID_O <= 1'b1;
        AXI_RRESP_O <= RESP_OKAY;
        case (word_of(AXI_ARADDR_I))
          REG_CTRL: AXI_RDATA_O <= {30'h0, ctrl};
          REG_CORE: AXI_RDATA_O <= {4'h0, MODE_O, ind_ptr, status, w};
          REG_PC: AXI_RDATA_O <= {15'h0, SLEEP_O, 4'h0, pc};
          default: begin
            AXI_RDATA_O <= 32'h0000_0000;
            AXI_RRESP_O <= RESP_SLVERR;
          end
        endcase
      end
      if (AXI_RVALID_O && AXI_RREADY_I) begin
        AXI_RVALID_O <= 1'b0;
        AXI_ARREADY_O <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  mov_fw_a: assert property (ex && (ir ==? 12'b0000_001?_????)
    |=> FILE_WE_O && FILE_WDATA_O == $past(w) && $stable(status))
    else $error("accumulator store wrong");
  mov_wf_a: assert property (ex && (ir ==? 12'b0010_000?_????)
    |=> w == $past(FILE_RDATA_I) && status[ST_Z] == ($past(f) == 8'h00))
    else $error("file load wrong");
  lit_w_a: assert property (ex && (ir ==? 12'b1100_????_????)
    |=> w == $past(ir[7:0]) && $stable(status))
    else $error("literal load wrong");
  inc_w_a: assert property (ex && (ir ==? 12'b0010_100?_????)
    |=> w == 8'($past(FILE_RDATA_I) + 8'h01))
    else $error("increment wrong");
  skip_set_a: assert property (ex && (ir ==? 12'b0011_110?_????)
    && FILE_RDATA_I == 8'hFF |=> skip ##2 !skip)
    else $error("skip not taken");
  skip_void_a: assert property (CE_I && state == ST_EXEC && skip
    |=> !FILE_WE_O && $stable(w) && state == ST_FETCH)
    else $error("skipped instruction acted");
  call_pc_a: assert property (ex && (ir ==? 12'b1001_????_????)
    |=> pc == {$past(status[7:5]), 1'b0, $past(ir[7:0])}
    && state == ST_STALL && stall_cnt == STALL_3CYC)
    else $error("call target wrong");
  jmp_pc_a: assert property (ex && (ir ==? 12'b101?_????_????)
    |=> pc == {$past(status[7:5]), $past(ir[8:0])})
    else $error("jump target wrong");
  bank_a: assert property (ex && (ir ==? 12'b0000_0001_1???)
    |=> ind_ptr[7:5] == $past(ir[2:0]))
    else $error("bank select wrong");
  page_a: assert property (ex && (ir ==? 12'b0000_0001_0???)
    |=> status[7:5] == $past(ir[2:0]))
    else $error("page select wrong");
  sleep_a: assert property (ex && ir == 12'b0000_0000_0011
    |=> SLEEP_O && WATCHDOG_CLR_O && status[ST_TO] && !status[ST_SLP])
    else $error("sleep entry wrong");

  call_c: cover property (push);
  pmr_c: cover property (pm_read && state == ST_STALL && stall_cnt == 3'h1);
  skip_c: cover property (CE_I && state == ST_EXEC && skip);
  sleep_c: cover property (SLEEP_O ##1 !SLEEP_O);
endmodule // rid_core

// [verification/rid_mem_model.sv]
// partner model: program memory, file registers and port control space
`timescale 1ns/1ps
module rid_mem_model (
  input wire logic clk_i,
  input wire logic [11:0] pmem_addr_i,
  output logic [11:0] pmem_data_o,
  input wire logic [7:0] file_addr_i,
  output logic [7:0] file_rdata_o,
  input wire logic file_we_i,
  input wire logic [7:0] file_wdata_i,
  input rid_pkg::rid_pctl_s pctl_i,
  output logic [7:0] pctl_rdata_o
);
  import rid_pkg::*;
  // -------------------------------------------------------------
  // storage, rom and ram loaded by the bench
  // -------------------------------------------------------------
  logic [11:0] rom [0:4095];
  logic [7:0] ram [0:255];
  logic [7:0] pctl_reg [0:7];
  // -------------------------------------------------------------
  // combinational reads, clocked writes
  // -------------------------------------------------------------
  assign pmem_data_o = rom[pmem_addr_i];
  assign file_rdata_o = ram[file_addr_i];
  assign pctl_rdata_o = pctl_reg[PORT_B];
  always @(posedge clk_i) begin
    if (file_we_i) begin
      ram[file_addr_i] <= file_wdata_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (pctl_i.we) begin
      pctl_reg[pctl_i.port] <= pctl_i.data;
    end
  end
endmodule // rid_mem_model

// [verification/risc_instruction_decoder_tb_top.sv]
// testbench: runs two programs through the core and checks them over the bus, in the partner memories and on the option port
`timescale 1ns/1ps
module risc_instruction_decoder_tb_top;
  import rid_pkg::*;
  logic mclk, rst_n;
  logic [7:0] awaddr, araddr, file_addr, file_rdata, file_wdata, pctl_rdata;
  logic awvalid, wvalid, bready, arvalid, rready, file_we;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [11:0] pmem_addr, pmem_data;
  rid_pctl_s pctl;
  rid_shadow_s shadow;
  logic [7:0] option;
  int err_count, tests_run;
  // -------------------------------------------------------------
  // design and partner
  // -------------------------------------------------------------
  rid_core i_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .CE_I(1'b1),
    .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
    .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb),
    .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
    .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
    .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
    .AXI_RREADY_I(rready), .PMEM_ADDR_O(pmem_addr),
    .PMEM_DATA_I(pmem_data), .FILE_ADDR_O(file_addr),
    .FILE_RDATA_I(file_rdata), .FILE_WE_O(file_we),
    .FILE_WDATA_O(file_wdata), .PCTL_O(pctl), .PCTL_RDATA_I(pctl_rdata),
    .MODE_O(), .OPTION_O(option), .SHADOW_I(shadow), .RTCNT_ADD_O(),
    .RTCNT_ADDEND_O(), .WATCHDOG_CLR_O(), .PRESC_CLR_O(), .SLEEP_O(),
    .WAKE_I(1'b0));
  rid_mem_model i_mem (.clk_i(mclk), .pmem_addr_i(pmem_addr),
    .pmem_data_o(pmem_data), .file_addr_i(file_addr),
    .file_rdata_o(file_rdata), .file_we_i(file_we),
    .file_wdata_i(file_wdata), .pctl_i(pctl),
    .pctl_rdata_o(pctl_rdata));
  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] resp);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    resp = 2'h3;
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) chk(32'h0, 32'h1, "write hang");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] resp);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    resp = 2'h3;
    v = 32'h0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) chk(32'h0, 32'h1, "read hang");
  endtask
  task automatic stop_test;
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // clock and watchdog
  // -------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    stop_test;
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    shadow = '0;
    err_count = 0;
    tests_run = 0;
    for (int i = 0; i < 4096; i++) begin
      i_mem.rom[i] = 12'h000;
    end
    i_mem.ram[8'h11] = 8'h33;
    i_mem.ram[8'h12] = 8'hFF;
    i_mem.ram[8'h13] = 8'hA5;
    i_mem.ram[8'hB4] = 8'hC5;
    i_mem.rom[12'h000] = 12'hC5A;
    i_mem.rom[12'h001] = 12'h030;
    i_mem.rom[12'h002] = 12'h3D2;
    i_mem.rom[12'h003] = 12'h031;
    i_mem.rom[12'h004] = 12'h393;
    i_mem.rom[12'h005] = 12'h035;
    i_mem.rom[12'h006] = 12'h056;
    i_mem.rom[12'h007] = 12'h042;
    i_mem.rom[12'h008] = 12'h036;
    i_mem.rom[12'h009] = 12'h01D;
    i_mem.rom[12'h00A] = 12'h011;
    i_mem.rom[12'h00B] = 12'hA0D;
    i_mem.rom[12'h20D] = 12'h9F0;
    i_mem.rom[12'h2F0] = 12'h8C3;
    i_mem.rom[12'h20E] = 12'h094;
    i_mem.rom[12'h20F] = 12'h035;
    i_mem.rom[12'h210] = 12'hA10;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    axi_rd(REG_CTRL, d, r);
    chk(d, 32'h1, "ctrl reset");
    repeat (200) @(posedge mclk);
    axi_rd(REG_CORE, d, r);
    chk(d[27:24], 32'h6, "mode");
    chk(d[23:16], 32'hA0, "pointer");
    chk(d[15:13], 32'h1, "page");
    chk(d[12:8], 32'h1B, "flags");
    chk(d[7:0], 32'h01, "acc");
    axi_rd(REG_PC, d, r);
    chk(d[11:1], 32'h108, "pc");
    chk(d[16], 32'h0, "sleep");
    chk(i_mem.ram[8'h10], 32'h5A, "store");
    chk(i_mem.ram[8'h11], 32'h33, "skip");
    chk(i_mem.ram[8'h15], 32'h5A, "swap");
    chk(i_mem.ram[8'h16], 32'h06, "mode read");
    chk(i_mem.ram[8'hB5], 32'h01, "sub");
    axi_wr(REG_CORE, 32'h0, r);
    chk(r, RESP_SLVERR, "ro write");
    axi_rd(8'h0C, d, r);
    chk(r, RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    axi_wr(REG_CTRL, 32'h0, r);
    chk(r, RESP_OKAY, "ctrl write");
    axi_rd(REG_CTRL, d, r);
    chk(d, 32'h0, "ctrl read");
    // second program after a mid-run reset
    rst_n <= 1'b0;
    i_mem.ram[8'h17] = 8'h00;
    i_mem.rom[12'h84B] = 12'h7E1;
    i_mem.rom[12'h000] = 12'h213;
    i_mem.rom[12'h001] = 12'h03A;
    i_mem.rom[12'h002] = 12'h253;
    i_mem.rom[12'h003] = 12'h03B;
    i_mem.rom[12'h004] = 12'h0D3;
    i_mem.rom[12'h005] = 12'h03C;
    i_mem.rom[12'h006] = 12'h313;
    i_mem.rom[12'h007] = 12'h03D;
    i_mem.rom[12'h008] = 12'h353;
    i_mem.rom[12'h009] = 12'h03E;
    i_mem.rom[12'h00A] = 12'h002;
    i_mem.rom[12'h00B] = 12'h006;
    i_mem.rom[12'h00C] = 12'h058;
    i_mem.rom[12'h00D] = 12'hC3C;
    i_mem.rom[12'h00E] = 12'h006;
    i_mem.rom[12'h00F] = 12'h03F;
    i_mem.rom[12'h010] = 12'h041;
    i_mem.rom[12'h011] = 12'h034;
    i_mem.rom[12'h012] = 12'h042;
    i_mem.rom[12'h013] = 12'h039;
    i_mem.rom[12'h014] = 12'h237;
    i_mem.rom[12'h015] = 12'h003;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (200) @(posedge mclk);
    axi_rd(REG_CORE, d, r);
    chk(d, 32'h0700_1507, "core after sleep");
    axi_rd(REG_PC, d, r);
    chk(d, 32'h0001_0016, "pc after sleep");
    chk(option, 32'h4B, "option");
    chk(i_mem.pctl_reg[6], 32'h3C, "port write");
    chk(i_mem.ram[8'h1A], 32'hA5, "file load");
    chk(i_mem.ram[8'h1B], 32'h5A, "inverse");
    chk(i_mem.ram[8'h1C], 32'hA4, "decrement");
    chk(i_mem.ram[8'h1D], 32'h52, "rotate right");
    chk(i_mem.ram[8'h1E], 32'h4B, "rotate left");
    chk(i_mem.ram[8'h1F], 32'h4B, "exchange");
    chk(i_mem.ram[8'h14], 32'hE1, "pmem word");
    chk(i_mem.ram[8'h19], 32'h07, "pmem mode");
    chk(i_mem.ram[8'h17], 32'h00, "test rewrite");
    stop_test;
  end
endmodule // risc_instruction_decoder_tb_top
